// ### rtl/sdc_pkg.sv
package sdc_pkg;

  // Host word to memory beat geometry.
  localparam int SDC_BEATS_PER_WORD = 4;
  localparam int SDC_BEAT_W = 72;
  localparam int SDC_PAYLOAD_W = 64;
  localparam int SDC_PAD_W = 8;
  localparam int SDC_POW2_CAP_W = 256;

  // Register map of the plain register port.
  localparam int SDC_REG_ADDR_W = 4;
  localparam logic [3:0] SDC_OFF_CTRL = 4'h0;
  localparam logic [3:0] SDC_OFF_APD_CYCLES = 4'h4;
  localparam logic [3:0] SDC_OFF_STATUS = 4'h8;

  // Field positions.
  localparam int SDC_CTRL_APD_EN_BIT = 0;
  localparam int SDC_STAT_PD_BIT = 0;
  localparam int SDC_STAT_SR_BIT = 1;
  localparam int SDC_STAT_DPD_BIT = 2;
  localparam int SDC_STAT_BUSY_BIT = 3;

  // Values after reset and limits of the idle threshold.
  localparam logic SDC_APD_EN_RESET = 1'b0;
  localparam int SDC_APD_CNT_W = 16;
  localparam logic [15:0] SDC_APD_CYCLES_RESET = 16'h0010;
  localparam logic [15:0] SDC_APD_CYCLES_MIN = 16'h0001;
  localparam logic [15:0] SDC_APD_CYCLES_MAX = 16'hffff;

  // Commands handed to the memory sequencer.
  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_WRITE,
    CMD_READ,
    CMD_PD_ENTER,
    CMD_PD_EXIT,
    CMD_SR_ENTER,
    CMD_SR_EXIT,
    CMD_DPD_ENTER,
    CMD_DPD_EXIT
  } sdc_cmd_type;

  // Controller states.
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_WRITE,
    ST_READ,
    ST_PD,
    ST_SR,
    ST_DPD
  } sdc_state_type;

  // Largest power of two not above n.
  function automatic int sdc_pow2_floor(input int n);
    int p;
    p = 1;
    while (p * 2 <= n) begin
      p = p * 2;
    end
    return p;
  endfunction

endpackage

// ### rtl/sdc_beat_pack.sv
`timescale 1ns/1ps
module sdc_beat_pack import sdc_pkg::*; #(
  parameter bit BYTE_EN_EN = 1'b1,
  parameter bit DM_EN = 1'b1
) (
  // Host word and its byte mask.
  input wire logic [SDC_POW2_CAP_W-1:0] word,
  input wire logic [SDC_POW2_CAP_W/8-1:0] byte_en,
  // Beat select.
  input wire logic [1:0] idx,
  // Memory beat.
  output logic [SDC_BEAT_W-1:0] beat,
  output logic [SDC_BEAT_W/8-1:0] dm
);

  logic [SDC_PAYLOAD_W-1:0] payload;
  logic [SDC_PAYLOAD_W/8-1:0] lane_en;

  // Slice the selected 64-bit quarter, lowest quarter first.
  always_comb begin
    payload = word[idx*SDC_PAYLOAD_W +: SDC_PAYLOAD_W];
    lane_en = byte_en[idx*(SDC_PAYLOAD_W/8) +: SDC_PAYLOAD_W/8];
  end

  // The pad byte is always zero and never masked, so it is written like any other byte.
  always_comb begin
    beat = {{SDC_PAD_W{1'b0}}, payload};
    if (BYTE_EN_EN && DM_EN) begin
      dm = {1'b0, ~lane_en};
    end else begin
      dm = '0;
    end
  end

endmodule // sdc_beat_pack

// ### rtl/sdc_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - With the power-of-two option the host data width is rounded down to a power of two.
// - With that option the host data buses are never wider than 256 bits.
// - Each 256-bit host transfer is carried out as four consecutive 72-bit memory beats.
// - Every beat drives its top 8 bits as zero and carries the payload in its low 64 bits.
// - The four beats of one host word form a whole burst of 4 or half of a burst of 8.
// - A maximum host burst length sets the largest burst and the burst-count width.
// - With byte enables on, the host byte mask drives the data-mask pins, which must exist.
// - Without byte enables every byte is enabled and the mask pins stay unmasked.
// - Host address width and host data width are parameters that size the host bus.
// - With self-refresh controls on, a top-level request decides entry and exit.
// - Deep power-down requests exist only for LPDDR2 memory and choose its entry.
// - With auto power-down on, the memory enters power-down after the set idle cycles.
// - The idle threshold takes values from 1 to 65535 controller cycles.
module sdc_ctrl import sdc_pkg::*; #(
  parameter int ADDR_W = 25,
  parameter int NAT_DATA_W = 288,
  parameter bit POW2_EN = 1'b1,
  parameter int MAX_BURST = 64,
  parameter bit BYTE_EN_EN = 1'b1,
  parameter bit DM_EN = 1'b1,
  parameter int MEM_BL = 8,
  parameter bit SR_EN = 1'b1,
  parameter bit IS_LPDDR2 = 1'b0,
  parameter bit DPD_EN = 1'b0,
  parameter bit APD_EN = 1'b1,
  localparam int POW2_W = sdc_pow2_floor(NAT_DATA_W),
  localparam int HOST_DATA_W = POW2_EN ?
    ((POW2_W > SDC_POW2_CAP_W) ? SDC_POW2_CAP_W : POW2_W) : NAT_DATA_W,
  localparam int BCW = $clog2(MAX_BURST) + 1
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Register port.
  input wire logic [SDC_REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Host bus.
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [HOST_DATA_W-1:0] host_wdata,
  input wire logic [HOST_DATA_W/8-1:0] host_byte_mask,
  input wire logic [BCW-1:0] host_burst_count,
  input wire logic host_write_req,
  input wire logic host_read_req,
  output logic host_wait_req,
  output logic [HOST_DATA_W-1:0] host_rdata,
  output logic host_rdata_valid,
  // Low-power requests and status.
  input wire logic sr_req,
  input wire logic dpd_req,
  output logic pd_active,
  output logic sr_active,
  output logic dpd_active,
  // Memory sequencer side.
  output sdc_cmd_type mem_cmd,
  output logic [ADDR_W-1:0] mem_cmd_addr,
  output logic [BCW-1:0] mem_cmd_burst,
  output logic mem_beat_valid,
  output logic mem_beat_first,
  output logic [SDC_BEAT_W-1:0] mem_wdata,
  output logic [SDC_BEAT_W/8-1:0] memory_write_mask_pins,
  input wire logic [SDC_BEAT_W-1:0] mem_rdata,
  input wire logic mem_rdata_valid
);

  localparam bit DPD_OK = DPD_EN && IS_LPDDR2;

  // Refuse builds that the controller cannot serve.
  if (HOST_DATA_W != SDC_BEATS_PER_WORD * SDC_PAYLOAD_W) begin : g_bad_width
    $error("Host data width must come to four 64-bit beats");
  end
  if (BYTE_EN_EN && !DM_EN) begin : g_bad_be
    $error("Byte enables need the data-mask pins");
  end
  if (DPD_EN && !IS_LPDDR2) begin : g_bad_dpd
    $error("Deep power-down is offered for LPDDR2 only");
  end
  if (MEM_BL != 4 && MEM_BL != 8) begin : g_bad_bl
    $error("Memory burst length must be 4 or 8");
  end
  if (MAX_BURST < 1 || ADDR_W < 1) begin : g_bad_burst
    $error("Burst length and address width must be positive");
  end

  sdc_state_type state_ff, nxt_state;
  sdc_cmd_type nxt_cmd;
  logic shifting_ff, nxt_shifting;
  logic [1:0] beat_idx_ff;
  logic [BCW-1:0] words_left_ff, nxt_words_left;
  logic [HOST_DATA_W-1:0] wword_ff;
  logic [HOST_DATA_W/8-1:0] wmask_ff;
  logic half_ff;
  logic word_first_ff;
  logic [BCW+1:0] rd_left_ff;
  logic [1:0] rd_idx_ff;
  logic [HOST_DATA_W-1:0] rbuf_ff;
  logic nxt_wait;
  logic [SDC_APD_CNT_W-1:0] idle_cnt_ff;
  logic apd_en_ff;
  logic [SDC_APD_CNT_W-1:0] apd_cycles_ff;
  logic take_wr, take_rd, any_req, apd_go;
  logic [BCW-1:0] burst_eff;
  logic [SDC_BEAT_W-1:0] beat;
  logic [SDC_BEAT_W/8-1:0] beat_dm;

  // A request is taken only while the registered wait request is low.
  assign take_wr = host_write_req && !host_wait_req;
  assign take_rd = host_read_req && !host_wait_req && !host_write_req;
  assign any_req = host_write_req || host_read_req;
  assign burst_eff = (host_burst_count == '0) ? BCW'(1) : host_burst_count;
  assign apd_go = APD_EN && apd_en_ff && (idle_cnt_ff >= apd_cycles_ff);

  // Next state and command; host service outranks low-power entry.
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = CMD_NOP;
    case (state_ff)
      ST_ACTIVE: begin
        if (take_wr) begin
          nxt_state = ST_WRITE;
          nxt_cmd = CMD_WRITE;
        end else if (take_rd) begin
          nxt_state = ST_READ;
          nxt_cmd = CMD_READ;
        end else if (DPD_OK && dpd_req) begin
          nxt_state = ST_DPD;
          nxt_cmd = CMD_DPD_ENTER;
        end else if (SR_EN && sr_req) begin
          nxt_state = ST_SR;
          nxt_cmd = CMD_SR_ENTER;
        end else if (!any_req && apd_go) begin
          nxt_state = ST_PD;
          nxt_cmd = CMD_PD_ENTER;
        end
      end
      ST_WRITE: begin
        if (!shifting_ff && words_left_ff == '0) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_READ: begin
        if (rd_left_ff == '0) begin
          nxt_state = ST_ACTIVE;
        end
      end
      ST_PD: begin
        if (any_req || (SR_EN && sr_req) || (DPD_OK && dpd_req)) begin
          nxt_state = ST_ACTIVE;
          nxt_cmd = CMD_PD_EXIT;
        end
      end
      ST_SR: begin
        if (!sr_req) begin
          nxt_state = ST_ACTIVE;
          nxt_cmd = CMD_SR_EXIT;
        end
      end
      ST_DPD: begin
        if (!dpd_req) begin
          nxt_state = ST_ACTIVE;
          nxt_cmd = CMD_DPD_EXIT;
        end
      end
      default: begin
        nxt_state = ST_ACTIVE;
      end
    endcase
  end

  // Beat shifter and word count of a write burst.
  always_comb begin
    nxt_shifting = shifting_ff;
    nxt_words_left = words_left_ff;
    if (take_wr) begin
      nxt_shifting = 1'b1;
      nxt_words_left = (state_ff == ST_ACTIVE) ? burst_eff - BCW'(1) : words_left_ff - BCW'(1);
    end else if (shifting_ff && beat_idx_ff == 2'(SDC_BEATS_PER_WORD - 1)) begin
      nxt_shifting = 1'b0;
    end
  end

  // Wait stays high in every state except idle active and between write words.
  always_comb begin
    nxt_wait = !((nxt_state == ST_ACTIVE && nxt_cmd == CMD_NOP) ||
                 (nxt_state == ST_WRITE && !nxt_shifting && nxt_words_left != '0));
  end

  // Controller state and power status flags.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_ACTIVE;
      host_wait_req <= 1'b1;
      pd_active <= 1'b0;
      sr_active <= 1'b0;
      dpd_active <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      host_wait_req <= nxt_wait;
      pd_active <= (nxt_state == ST_PD);
      sr_active <= (nxt_state == ST_SR);
      dpd_active <= (nxt_state == ST_DPD);
    end
  end

  // Command port toward the sequencer, one cycle per command.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_cmd <= CMD_NOP;
      mem_cmd_addr <= '0;
      mem_cmd_burst <= '0;
    end else if (ce) begin
      mem_cmd <= nxt_cmd;
      if (nxt_cmd == CMD_WRITE || nxt_cmd == CMD_READ) begin
        mem_cmd_addr <= host_addr;
        mem_cmd_burst <= burst_eff;
      end
    end
  end

  // Write word capture and beat counter.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shifting_ff <= 1'b0;
      beat_idx_ff <= 2'h0;
      words_left_ff <= '0;
      wword_ff <= '0;
      wmask_ff <= '0;
      word_first_ff <= 1'b0;
      half_ff <= 1'b0;
    end else if (ce) begin
      shifting_ff <= nxt_shifting;
      words_left_ff <= nxt_words_left;
      if (take_wr) begin
        wword_ff <= host_wdata;
        wmask_ff <= BYTE_EN_EN ? host_byte_mask : '1;
        beat_idx_ff <= 2'h0;
        word_first_ff <= 1'b1;
        half_ff <= (state_ff == ST_ACTIVE) ? 1'b0 : ~half_ff;
      end else if (shifting_ff) begin
        beat_idx_ff <= beat_idx_ff + 2'h1;
        word_first_ff <= 1'b0;
      end
    end
  end

  // Beat slicer; combinational so the output flops below stay the only stage.
  sdc_beat_pack #(
    .BYTE_EN_EN(BYTE_EN_EN),
    .DM_EN(DM_EN)
  ) u_pack (
    .word(wword_ff),
    .byte_en(wmask_ff),
    .idx(beat_idx_ff),
    .beat(beat),
    .dm(beat_dm)
  );

  // Registered memory beat; a burst of 8 starts only on even words.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_beat_valid <= 1'b0;
      mem_beat_first <= 1'b0;
      mem_wdata <= '0;
      memory_write_mask_pins <= '0;
    end else if (ce) begin
      mem_beat_valid <= shifting_ff;
      mem_beat_first <= shifting_ff && word_first_ff && (MEM_BL == 4 || !half_ff);
      mem_wdata <= shifting_ff ? beat : '0;
      memory_write_mask_pins <= shifting_ff ? beat_dm : '0;
    end
  end

  // Read beats are gathered four at a time into one host word.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_left_ff <= '0;
      rd_idx_ff <= 2'h0;
      rbuf_ff <= '0;
      host_rdata <= '0;
      host_rdata_valid <= 1'b0;
    end else if (ce) begin
      host_rdata_valid <= 1'b0;
      if (take_rd) begin
        rd_left_ff <= (BCW+2)'(burst_eff) << 2;
        rd_idx_ff <= 2'h0;
      end else if (state_ff == ST_READ && mem_rdata_valid && rd_left_ff != '0) begin
        rd_left_ff <= rd_left_ff - (BCW+2)'(1);
        rd_idx_ff <= rd_idx_ff + 2'h1;
        rbuf_ff[rd_idx_ff*SDC_PAYLOAD_W +: SDC_PAYLOAD_W] <= mem_rdata[SDC_PAYLOAD_W-1:0];
        if (rd_idx_ff == 2'h3) begin
          host_rdata <= {mem_rdata[SDC_PAYLOAD_W-1:0], rbuf_ff[3*SDC_PAYLOAD_W-1:0]};
          host_rdata_valid <= 1'b1;
        end
      end
    end
  end

  // Idle counter saturates so a long quiet spell cannot wrap back below the threshold.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt_ff <= '0;
    end else if (ce) begin
      if (any_req || nxt_cmd != CMD_NOP || state_ff != ST_ACTIVE || mem_rdata_valid) begin
        idle_cnt_ff <= '0;
      end else if (idle_cnt_ff != SDC_APD_CYCLES_MAX) begin
        idle_cnt_ff <= idle_cnt_ff + 16'h0001;
      end
    end
  end

  // Register writes; a threshold of zero is raised to the least legal value.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      apd_en_ff <= SDC_APD_EN_RESET;
      apd_cycles_ff <= SDC_APD_CYCLES_RESET;
    end else if (ce && reg_write) begin
      if (reg_addr == SDC_OFF_CTRL) begin
        apd_en_ff <= reg_wdata[SDC_CTRL_APD_EN_BIT];
      end
      if (reg_addr == SDC_OFF_APD_CYCLES) begin
        apd_cycles_ff <= (reg_wdata[15:0] == 16'h0000) ?
          SDC_APD_CYCLES_MIN : reg_wdata[15:0];
      end
    end
  end

  // Register reads answer one cycle later; unmapped offsets read as zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_read) begin
        case (reg_addr)
          SDC_OFF_CTRL: reg_rdata[SDC_CTRL_APD_EN_BIT] <= apd_en_ff;
          SDC_OFF_APD_CYCLES: reg_rdata[15:0] <= apd_cycles_ff;
          SDC_OFF_STATUS: begin
            reg_rdata[SDC_STAT_PD_BIT] <= pd_active;
            reg_rdata[SDC_STAT_SR_BIT] <= sr_active;
            reg_rdata[SDC_STAT_DPD_BIT] <= dpd_active;
            reg_rdata[SDC_STAT_BUSY_BIT] <= (state_ff == ST_WRITE || state_ff == ST_READ);
          end
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks next to the logic they guard.
  a_pad_zero: assert property (@(posedge clk) disable iff (!rstn || !ce)
    mem_beat_valid |-> mem_wdata[SDC_BEAT_W-1:SDC_PAYLOAD_W] == 8'h00)
    else $error("Pad byte of a memory beat is not zero");

  a_four_beats: assert property (@(posedge clk) disable iff (!rstn || !ce)
    take_wr |=> ##1 mem_beat_valid [*4] ##1 !mem_beat_valid)
    else $error("Host write word did not give exactly four beats");

  // The pad lane is never masked; without byte enables no lane is masked at all.
  a_mask_clear: assert property (@(posedge clk) disable iff (!rstn || !ce)
    mem_beat_valid |-> !memory_write_mask_pins[SDC_BEAT_W/8-1] &&
      (BYTE_EN_EN || memory_write_mask_pins == '0))
    else $error("Mask pins asserted on an enabled byte");

  a_burst_start: assert property (@(posedge clk) disable iff (!rstn || !ce)
    mem_beat_first |-> mem_beat_valid && !$past(mem_beat_valid))
    else $error("Burst start not on the first beat of a word");

  a_wait_lowpwr: assert property (@(posedge clk) disable iff (!rstn || !ce)
    (pd_active || sr_active || dpd_active) |-> host_wait_req)
    else $error("Host taken while memory is in a low-power state");

  a_apd_count: assert property (@(posedge clk) disable iff (!rstn || !ce)
    $rose(pd_active) |-> $past(idle_cnt_ff) >= $past(apd_cycles_ff) && $past(apd_en_ff))
    else $error("Power-down entered before the idle threshold");

  a_apd_range: assert property (@(posedge clk) disable iff (!rstn || !ce)
    apd_cycles_ff != 16'h0000)
    else $error("Idle threshold below one cycle");

  a_pd_exit: assert property (@(posedge clk) disable iff (!rstn || !ce)
    (pd_active && any_req) |=> mem_cmd == CMD_PD_EXIT && !pd_active ##1 !host_wait_req)
    else $error("Power-down not left on a host request");

  a_idle_reset: assert property (@(posedge clk) disable iff (!rstn || !ce)
    any_req |=> idle_cnt_ff == '0)
    else $error("Idle count not restarted by a request");

  a_sr_follow: assert property (@(posedge clk) disable iff (!rstn || !ce)
    (sr_active && !sr_req) |=> mem_cmd == CMD_SR_EXIT && !sr_active)
    else $error("Self-refresh not left when the request fell");

  // A build without the deep power-down option must ignore its request line.
  a_dpd_lpddr2: assert property (@(posedge clk) disable iff (!rstn || !ce)
    (dpd_req && !DPD_OK) |=> !dpd_active && mem_cmd != CMD_DPD_ENTER)
    else $error("Deep power-down entered on a build without it");

endmodule // sdc_ctrl

// ### dv/sdc_seq_model.sv
`timescale 1ns/1ps
// Memory sequencer stand-in: answers every read command with four beats per host word.
module sdc_seq_model import sdc_pkg::*; #(
  parameter int ADDR_W = 25,
  parameter int BCW = 7
) (
  // Clock, reset and pacing.
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  // Commands from the controller.
  input sdc_cmd_type mem_cmd,
  input wire logic [ADDR_W-1:0] mem_cmd_addr,
  input wire logic [BCW-1:0] mem_cmd_burst,
  // Read beats back to the controller.
  output logic [SDC_BEAT_W-1:0] mem_rdata,
  output logic mem_rdata_valid
);
  int left;
  int idx;
  logic gap;
  logic [ADDR_W-1:0] base;

  // Payload of beat k of a burst; the bench rebuilds expected read words from it.
  function automatic logic [63:0] pay(input logic [ADDR_W-1:0] a, input int k);
    return {32'(a) ^ 32'h3c3c0000, 32'(k) * 32'h01000193 + 32'h0000beef};
  endfunction

  // The pad byte is sent non-zero on purpose, so a controller that keeps it shows up.
  // Slow pacing leaves a gap after each beat, and idle data toggles instead of holding.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left <= 0;
      idx <= 0;
      gap <= 1'b0;
      base <= '0;
      mem_rdata <= '0;
      mem_rdata_valid <= 1'b0;
    end else if (mem_cmd == CMD_READ) begin
      left <= ((mem_cmd_burst == '0) ? 1 : int'(mem_cmd_burst)) * SDC_BEATS_PER_WORD;
      idx <= 0;
      base <= mem_cmd_addr;
      mem_rdata <= ~mem_rdata;
      mem_rdata_valid <= 1'b0;
    end else if (left > 0 && !(slow && gap)) begin
      mem_rdata <= {8'h5a, pay(base, idx)};
      mem_rdata_valid <= 1'b1;
      left <= left - 1;
      idx <= idx + 1;
      gap <= 1'b1;
    end else begin
      mem_rdata <= ~mem_rdata;
      mem_rdata_valid <= 1'b0;
      gap <= 1'b0;
    end
  end
endmodule // sdc_seq_model

// ### dv/sdc_ctrl_tb.sv
`timescale 1ns/1ps
// Self-checking bench: host bursts, beat packing, registers and low-power entry and exit.
module sdc_ctrl_tb;
  import sdc_pkg::*;
  localparam int AW = 25;
  localparam int HW = 256;
  localparam int BCW = 7;

  // Bench drives, given a value at time zero except seed, which the main sequence sets, and exp_addr and exp_n, which the first host task sets.
  logic clk = 1'b0;
  logic rstn = 1'b0, slow = 1'b0, sr_req = 1'b0, dpd_req = 1'b0;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, seed;
  logic reg_write = 1'b0, reg_read = 1'b0, host_write_req = 1'b0, host_read_req = 1'b0;
  logic [AW-1:0] host_addr = '0, exp_addr;
  logic [HW-1:0] host_wdata = '0;
  logic [31:0] host_byte_mask = '0;
  logic [BCW-1:0] host_burst_count = '0, exp_n;
  // Design outputs.
  logic [31:0] reg_rdata;
  logic host_wait_req, host_rdata_valid, pd_active, sr_active, dpd_active;
  logic [HW-1:0] host_rdata;
  sdc_cmd_type mem_cmd;
  logic [AW-1:0] mem_cmd_addr;
  logic [BCW-1:0] mem_cmd_burst;
  logic mem_beat_valid, mem_beat_first, mem_rdata_valid;
  logic [SDC_BEAT_W-1:0] mem_wdata, mem_rdata;
  logic [8:0] memory_write_mask_pins;
  // Bookkeeping.
  int num_errors = 0;
  int n_tests = 0;
  logic [81:0] expq[$];
  sdc_cmd_type cmdq[$];

  sdc_ctrl dut (
    .clk(clk), .rstn(rstn), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_byte_mask(host_byte_mask), .host_burst_count(host_burst_count),
    .host_write_req(host_write_req), .host_read_req(host_read_req),
    .host_wait_req(host_wait_req), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid), .sr_req(sr_req), .dpd_req(dpd_req),
    .pd_active(pd_active), .sr_active(sr_active), .dpd_active(dpd_active),
    .mem_cmd(mem_cmd), .mem_cmd_addr(mem_cmd_addr), .mem_cmd_burst(mem_cmd_burst),
    .mem_beat_valid(mem_beat_valid), .mem_beat_first(mem_beat_first),
    .mem_wdata(mem_wdata), .memory_write_mask_pins(memory_write_mask_pins),
    .mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid)
  );

  sdc_seq_model #(.ADDR_W(AW), .BCW(BCW)) u_mdl (
    .clk(clk), .rstn(rstn), .slow(slow), .mem_cmd(mem_cmd), .mem_cmd_addr(mem_cmd_addr),
    .mem_cmd_burst(mem_cmd_burst), .mem_rdata(mem_rdata), .mem_rdata_valid(mem_rdata_valid)
  );

  // The 25 ns controller clock.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Repeatable pseudo-random source.
  function automatic logic [31:0] nxt_rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Beat k of word w: zero pad byte, payload quarter k, mask set on disabled bytes only.
  function automatic logic [81:0] exp_beat(logic [HW-1:0] d, logic [31:0] m, int k, int w);
    return {(k == 0) && (w % 2 == 0), 8'h00, d[64*k+:64], 1'b0, ~m[8*k+:8]};
  endfunction

  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Waits at falling edges for a level; a bound that runs out ends the run as a failure.
  task automatic wait_lvl(ref logic s, input logic v, output int c);
    for (c = 0; c < 400; c++) begin
      @(negedge clk);
      if (s === v) break;
    end
    if (c == 400) begin
      num_errors++;
      end_sim();
    end
  endtask

  // The request is held until the edge that sees the wait request low, then that edge passes.
  task automatic wait_take();
    int c;
    wait_lvl(host_wait_req, 1'b0, c);
    @(posedge clk);
  endtask

  // Register strobes; a spare cycle after each keeps two writes from meeting in one step.
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    reg_rd(a, d);
    chk(d, e);
  endtask

  // Mode 1 enables every byte, mode 2 none, otherwise the mask is random.
  task automatic host_write(input logic [AW-1:0] a, input int n, input int mode);
    logic [HW-1:0] d;
    logic [31:0] m;
    exp_addr = a;
    exp_n = BCW'(n);
    for (int w = 0; w < n; w++) begin
      for (int j = 0; j < 8; j++) d[32*j+:32] = nxt_rnd();
      m = (mode == 1) ? 32'hffffffff : (mode == 2) ? 32'h0 : nxt_rnd();
      host_addr <= a;
      host_burst_count <= BCW'(n);
      host_wdata <= d;
      host_byte_mask <= m;
      host_write_req <= 1'b1;
      wait_take();
      for (int k = 0; k < 4; k++) expq.push_back(exp_beat(d, m, k, w));
    end
    host_write_req <= 1'b0;
    @(posedge clk);
  endtask

  task automatic host_read(input logic [AW-1:0] a, input int n);
    logic [HW-1:0] e;
    int c;
    exp_addr = a;
    exp_n = BCW'(n);
    host_addr <= a;
    host_burst_count <= BCW'(n);
    host_read_req <= 1'b1;
    wait_take();
    host_read_req <= 1'b0;
    for (int w = 0; w < n; w++) begin
      for (int k = 0; k < 4; k++) e[64*k+:64] = u_mdl.pay(a, 4 * w + k);
      wait_lvl(host_rdata_valid, 1'b1, c);
      chk(host_rdata, e);
    end
    @(posedge clk);
  endtask

  task automatic chk_cmds(input sdc_cmd_type a, input sdc_cmd_type b, input sdc_cmd_type e);
    chk(cmdq.size(), 3);
    if (cmdq.size() == 3) chk({cmdq[0], cmdq[1], cmdq[2]}, {a, b, e});
    cmdq.delete();
  endtask

  // Monitor: beats against the queue, command log, and hold-off in every low-power state.
  always @(negedge clk) begin
    if (rstn === 1'b1) begin
      if (mem_beat_valid === 1'b1 && expq.size() == 0) chk(1, 0);
      else if (mem_beat_valid === 1'b1) chk({mem_beat_first, mem_wdata, memory_write_mask_pins},
        expq.pop_front());
      if (mem_cmd !== CMD_NOP) cmdq.push_back(mem_cmd);
      if (mem_cmd === CMD_WRITE || mem_cmd === CMD_READ) chk({mem_cmd_addr, mem_cmd_burst},
        {exp_addr, exp_n});
      if ((pd_active | sr_active | dpd_active) === 1'b1) chk(host_wait_req, 1'b1);
    end
  end

  // Main sequence.
  initial begin
    logic [31:0] d;
    int c;
    seed = 32'h160ef201;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(host_wait_req, 1'b1);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    // Reset values, an unmapped offset, and the limits of the idle threshold.
    rchk(SDC_OFF_CTRL, 32'h0);
    rchk(SDC_OFF_APD_CYCLES, 32'(SDC_APD_CYCLES_RESET));
    rchk(4'hc, 32'h0);
    reg_wr(SDC_OFF_APD_CYCLES, 32'h0);
    rchk(SDC_OFF_APD_CYCLES, 32'h1);
    reg_wr(SDC_OFF_APD_CYCLES, 32'hffff);
    rchk(SDC_OFF_APD_CYCLES, 32'hffff);
    reg_wr(SDC_OFF_APD_CYCLES, 32'h3);
    // Corner bursts: full mask, empty mask, the longest burst both ways, then a random mix.
    host_write(25'h0000100, 1, 1);
    host_write(25'h0000200, 2, 2);
    host_write(25'h1ffffc0, 64, 0);
    slow <= 1'b1;
    host_read(25'h0000300, 64);
    for (int i = 0; i < 10; i++) begin
      d = nxt_rnd();
      slow <= d[0];
      if (d[1]) host_write(AW'(d[31:8]), int'(d[4:2]) + 1, 0);
      else host_read(AW'(d[31:8]), int'(d[4:2]) + 1);
    end
    // Self-refresh entered on request; a write waits until the exit.
    cmdq.delete();
    sr_req <= 1'b1;
    wait_lvl(sr_active, 1'b1, c);
    @(posedge clk);
    reg_rd(SDC_OFF_STATUS, d);
    chk(d[3:0], 4'h2);
    fork
      host_write(25'h0000400, 1, 0);
    join_none
    repeat (20) @(posedge clk);
    sr_req <= 1'b0;
    wait fork;
    wait_lvl(host_wait_req, 1'b0, c);
    chk_cmds(CMD_SR_ENTER, CMD_SR_EXIT, CMD_WRITE);
    // Deep power-down requests have no effect on this memory type.
    @(posedge clk);
    dpd_req <= 1'b1;
    repeat (10) @(negedge clk);
    chk({dpd_active, 32'(cmdq.size())}, 33'h0);
    @(posedge clk);
    dpd_req <= 1'b0;
    // Automatic power-down, wake-up by a write, and the idle count restarted after it.
    reg_wr(SDC_OFF_CTRL, 32'h1);
    wait_lvl(pd_active, 1'b1, c);
    @(posedge clk);
    reg_rd(SDC_OFF_STATUS, d);
    chk(d[3:0], 4'h1);
    host_write(25'h0000500, 1, 0);
    wait_lvl(host_wait_req, 1'b0, c);
    chk_cmds(CMD_PD_ENTER, CMD_PD_EXIT, CMD_WRITE);
    wait_lvl(pd_active, 1'b1, c);
    chk(c >= 2 && c <= 6, 1'b1);
    chk(expq.size(), 0);
    end_sim();
  end
endmodule // sdc_ctrl_tb
